// ===== rtl/pin_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - strobe low only for external writes
// - strobe is input during granted DMA
// - wait or stop drops run, halts
// - emulation muxes fetch marker onto run
// - wait holds run low until irq/reset
// - stop also freezes phase clock
// - run rising requests phase clock restart
// - gate bit starts/stops fast oscillator
// - select bit picks slow/fast phase source
// - osc drive outputs invert clock inputs
// - reset release sets run, loads config
// - grant low in phase low: DMA
// - grant high: processor drives bus
// - grant low in phase high: halt only
// - emulation traces internal accesses externally
// - reset low two cycles: low power
// - reset makes ports 0..2 inputs, buffers off
// - nine-cycle reset sequence before fetch
// - watchdog pulls reset pin low
// - port direction and data register behaviour
// - port 3 selects chip select or data
module pin_ctrl
  import pin_ctrl_pkg::*;
#(
  parameter logic [7:0] WDT_PULSE = WDT_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock pins
  input wire logic slow_osc_in_i,
  input wire logic fast_osc_in_i,
  output logic slow_osc_drive_n_o,
  output logic fast_osc_drive_n_o,
  output logic system_phase_clock_o,
  // control pins
  input wire logic bus_grant_in_i,
  input wire logic reset_n_pin_i,
  output logic reset_n_pin_o,
  output logic reset_n_pin_oe_o,
  input wire logic write_strobe_n_i,
  output logic write_strobe_n_o,
  output logic write_strobe_n_oe_o,
  output logic run_pin_o,
  // ports 0..2 (address low, address high, data)
  input wire logic [23:0] port_i,
  output logic [23:0] port_o,
  output logic [23:0] port_oe_o,
  // port 3
  input wire logic [7:0] chip_select_n_i,
  output logic [7:0] port3_o,
  // processor side
  input wire logic cpu_valid_i,
  input wire logic cpu_internal_i,
  input wire logic cpu_we_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic [7:0] cpu_idata_i,
  input wire logic cpu_sync_i,
  input wire logic wait_for_irq_instr_i,
  input wire logic stop_clock_instr_i,
  input wire logic irq_req_i,
  input wire logic wdt_timeout_i,
  output logic cpu_halt_o,
  output logic cpu_start_o,
  output logic clk_restart_req_o,
  output logic low_power_o,
  output logic [7:0] ext_rdata_o,
  output logic ext_rdata_valid_o,
  // dma side
  input wire logic [7:0] dma_rdata_i,
  output logic dma_we_o,
  output logic [15:0] dma_addr_o,
  output logic [7:0] dma_wdata_o
);

  typedef struct packed {
    logic [7:0] bus_config_reg;
    logic [7:0] tcr;
    logic [23:0] port_output_reg;
    logic [23:0] port_direction_reg;
    logic [7:0] p3_data;
    logic [7:0] port3_select_reg;
    logic system_phase_clock;
    logic rst_pin_d;
    logic run;
    logic clk_stopped;
    logic dma;
    logic low_power;
    logic [1:0] lp_cnt;
    logic [3:0] seq_cnt;
    logic [7:0] wdt_cnt;
    logic ack;
    logic [31:0] rdata;
    logic restart_req;
    logic cpu_start;
    logic halt;
    logic run_pin;
    logic strobe_out;
    logic strobe_oe;
    logic [23:0] pout;
    logic [23:0] poe;
    logic [7:0] p3_pin;
    logic slow_drv;
    logic fast_drv;
    logic rst_oe;
    logic dma_we;
    logic [15:0] dma_addr;
    logic [7:0] dma_wdata;
    logic [7:0] ext_rdata;
    logic ext_valid;
  } state_t;

  localparam state_t ST_RST = '{
    tcr: TCR_RST,
    port_output_reg: PORT_RST,
    port_direction_reg: PORT_RST,
    p3_data: PORT3_DATA_RST,
    port3_select_reg: PORT3_SEL_RST,
    system_phase_clock: 1'b1,
    run: 1'b1,
    strobe_out: 1'b1,
    p3_pin: PORT3_DATA_RST,
    slow_drv: 1'b1,
    fast_drv: 1'b1,
    default: '0
  };

  state_t st_r;
  state_t st_nxt;

  logic [28:0] sync_in;
  logic [28:0] sync_out;
  logic slow_s;
  logic fast_s;
  logic bg_s;
  logic rp_s;
  logic strobe_s;
  logic [23:0] port_s;

  assign sync_in = {port_i, write_strobe_n_i, reset_n_pin_i, bus_grant_in_i, fast_osc_in_i, slow_osc_in_i};

  sync_bank #(
    .WIDTH(29)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sync_in),
    .q_o(sync_out)
  );

  assign slow_s = sync_out[0];
  assign fast_s = sync_out[1];
  assign bg_s = sync_out[2];
  assign rp_s = sync_out[3];
  assign strobe_s = sync_out[4];
  assign port_s = sync_out[28:5];

  always_comb begin
    logic src;
    logic rise;
    logic fall;
    logic hi;
    logic emu;
    logic bus_mode;
    logic ext_cyc;
    logic wb_hit;
    logic [23:0] lvl;
    logic [7:0] sel_mask;
    logic [15:0] a_out;
    logic [7:0] d_out;
    logic d_oe;
    src = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    hi = 1'b0;
    emu = 1'b0;
    bus_mode = 1'b0;
    ext_cyc = 1'b0;
    wb_hit = 1'b0;
    lvl = '0;
    sel_mask = '0;
    a_out = '0;
    d_out = '0;
    d_oe = 1'b0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.restart_req = 1'b0;
    st_nxt.cpu_start = 1'b0;
    st_nxt.dma_we = 1'b0;
    st_nxt.ext_valid = 1'b0;

    // phase clock source and gating
    src = st_r.tcr[TCR_CLK_SEL] ? (fast_s & st_r.tcr[TCR_FAST_GATE]) : slow_s;
    st_nxt.system_phase_clock = (st_r.clk_stopped | st_r.low_power) ? 1'b1 : src;
    rise = ~st_r.system_phase_clock & st_nxt.system_phase_clock;
    fall = st_r.system_phase_clock & ~st_nxt.system_phase_clock;
    st_nxt.slow_drv = ~slow_s;
    st_nxt.fast_drv = ~(fast_s & st_r.tcr[TCR_FAST_GATE]);
    st_nxt.rst_pin_d = rp_s;

    // watchdog restart pulse on the reset pin
    if (wdt_timeout_i) begin
      st_nxt.wdt_cnt = WDT_PULSE;
    end else if (st_r.wdt_cnt != 8'h00) begin
      st_nxt.wdt_cnt = st_r.wdt_cnt - 8'h01;
    end
    st_nxt.rst_oe = (st_nxt.wdt_cnt != 8'h00);

    if (!rp_s) begin
      // reset pin held low
      st_nxt.bus_config_reg = BCR_NORM_INIT;
      st_nxt.tcr = TCR_RST;
      st_nxt.port_output_reg = PORT_RST;
      st_nxt.port_direction_reg = PORT_RST;
      st_nxt.p3_data = PORT3_DATA_RST;
      st_nxt.port3_select_reg = PORT3_SEL_RST;
      st_nxt.seq_cnt = 4'h0;
      st_nxt.dma = 1'b0;
      if (rise && st_r.lp_cnt != LOW_POWER_CYCLES) begin
        st_nxt.lp_cnt = st_r.lp_cnt + 2'h1;
      end
      st_nxt.low_power = (st_nxt.lp_cnt == LOW_POWER_CYCLES);
    end else if (!st_r.rst_pin_d) begin
      // reset release
      st_nxt.run = 1'b1;
      st_nxt.clk_stopped = 1'b0;
      st_nxt.low_power = 1'b0;
      st_nxt.lp_cnt = 2'h0;
      st_nxt.restart_req = 1'b1;
      st_nxt.bus_config_reg = bg_s ? BCR_NORM_INIT : BCR_EMU_INIT;
      st_nxt.seq_cnt = RESET_SEQ_CYCLES;
    end else begin
      // start-up sequence
      if (rise && st_r.seq_cnt != 4'h0) begin
        st_nxt.seq_cnt = st_r.seq_cnt - 4'h1;
        st_nxt.cpu_start = (st_r.seq_cnt == 4'h1);
      end
      // wait / stop and wake-up
      if (!st_r.run) begin
        if (irq_req_i) begin
          st_nxt.run = 1'b1;
          st_nxt.clk_stopped = 1'b0;
          st_nxt.restart_req = 1'b1;
        end
      end else if (st_r.system_phase_clock && !st_r.halt && (wait_for_irq_instr_i || stop_clock_instr_i)) begin
        st_nxt.run = 1'b0;
        st_nxt.clk_stopped = stop_clock_instr_i;
      end
      // bus grant direction control
      if (bg_s) begin
        st_nxt.dma = 1'b0;
      end else if (!st_r.system_phase_clock) begin
        st_nxt.dma = 1'b1;
      end
      // register writes
      if (wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack) begin
        if ({wb_adr_i[7:2], 2'b00} == OFF_BUS_CONFIG && wb_sel_i[0]) begin
          st_nxt.bus_config_reg = wb_dat_i[7:0];
        end
        if ({wb_adr_i[7:2], 2'b00} == OFF_TIMER_CTRL && wb_sel_i[0]) begin
          st_nxt.tcr = wb_dat_i[7:0] & TCR_WR_MASK;
        end
        for (int b = 0; b < 3; b++) begin
          if ({wb_adr_i[7:2], 2'b00} == OFF_PORT_DATA && wb_sel_i[b]) begin
            st_nxt.port_output_reg[8*b+:8] = wb_dat_i[8*b+:8];
          end
          if ({wb_adr_i[7:2], 2'b00} == OFF_PORT_DIR && wb_sel_i[b]) begin
            st_nxt.port_direction_reg[8*b+:8] = wb_dat_i[8*b+:8];
          end
        end
        if ({wb_adr_i[7:2], 2'b00} == OFF_PORT3 && wb_sel_i[0]) begin
          st_nxt.p3_data = wb_dat_i[7:0];
        end
        if ({wb_adr_i[7:2], 2'b00} == OFF_PORT3 && wb_sel_i[1]) begin
          st_nxt.port3_select_reg = wb_dat_i[15:8];
        end
      end
    end

    // pin levels, input buffers off during reset
    lvl = port_s & {24{rp_s}};

    // wishbone answer
    wb_hit = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.ack = wb_hit;
    if (wb_hit && !wb_we_i) begin
      case ({wb_adr_i[7:2], 2'b00})
        OFF_BUS_CONFIG: st_nxt.rdata = {24'h000000, st_r.bus_config_reg};
        OFF_TIMER_CTRL: st_nxt.rdata = {24'h000000, st_r.tcr};
        OFF_PORT_DATA: st_nxt.rdata = {8'h00, lvl};
        OFF_PORT_DIR: st_nxt.rdata = {8'h00, st_r.port_direction_reg};
        OFF_PORT3: st_nxt.rdata = {16'h0000, st_r.port3_select_reg, st_r.p3_data};
        OFF_STATUS: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rdata[ST_RUN] = st_r.run;
          st_nxt.rdata[ST_CLK_STOP] = st_r.clk_stopped;
          st_nxt.rdata[ST_DMA] = st_r.dma;
          st_nxt.rdata[ST_LOW_POWER] = st_r.low_power;
          st_nxt.rdata[ST_SEQ_BUSY] = (st_r.seq_cnt != 4'h0);
          st_nxt.rdata[ST_BUS_GRANT] = bg_s;
        end
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end

    // processor halt: stopped, grant low, in reset, or still sequencing
    st_nxt.halt = ~st_nxt.run | ~bg_s | ~rp_s | (st_nxt.seq_cnt != 4'h0);

    // run pin
    hi = st_nxt.system_phase_clock;
    emu = st_nxt.bus_config_reg[BCR_EMU];
    st_nxt.run_pin = (emu && !hi) ? cpu_sync_i : st_nxt.run;

    // external bus pins
    bus_mode = st_nxt.bus_config_reg[BCR_EXT_BUS] | emu | st_nxt.bus_config_reg[BCR_EXT_MEM];
    ext_cyc = cpu_valid_i & ~cpu_internal_i & ~st_nxt.halt;
    a_out = (cpu_internal_i && !emu) ? ADDR_ON_CHIP : cpu_addr_i;
    if (ext_cyc && cpu_we_i) begin
      d_out = cpu_wdata_i;
    end else if (cpu_internal_i && emu) begin
      d_out = cpu_we_i ? cpu_wdata_i : cpu_idata_i;
    end else begin
      d_out = DATA_ON_CHIP;
    end
    d_oe = hi & cpu_valid_i & ~(ext_cyc & ~cpu_we_i);
    st_nxt.strobe_oe = ~st_nxt.dma;
    st_nxt.strobe_out = ~(hi & ext_cyc & cpu_we_i & bus_mode);

    if (!rp_s) begin
      st_nxt.pout = '0;
      st_nxt.poe = '0;
    end else if (bus_mode && st_nxt.dma) begin
      st_nxt.pout = {dma_rdata_i, 16'h0000};
      st_nxt.poe = {{8{hi & strobe_s}}, 16'h0000};
    end else if (bus_mode) begin
      st_nxt.pout = {d_out, a_out};
      st_nxt.poe = {{8{d_oe}}, 16'hFFFF};
    end else begin
      st_nxt.pout = st_nxt.port_output_reg;
      st_nxt.poe = st_nxt.port_direction_reg;
    end

    // dma write into the addressed on-chip location
    if (st_nxt.dma && fall && !strobe_s) begin
      st_nxt.dma_we = 1'b1;
      st_nxt.dma_addr = port_s[15:0];
      st_nxt.dma_wdata = port_s[23:16];
    end

    // external read data capture at end of phase high
    if (!st_nxt.dma && fall && ext_cyc && !cpu_we_i) begin
      st_nxt.ext_rdata = port_s[23:16];
      st_nxt.ext_valid = 1'b1;
    end

    // port 3 chip select / data mux
    sel_mask = st_nxt.port3_select_reg | {st_nxt.bus_config_reg[BCR_EXT_MEM], 7'h00};
    st_nxt.p3_pin = (sel_mask & chip_select_n_i) | (~sel_mask & st_nxt.p3_data);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign slow_osc_drive_n_o = st_r.slow_drv;
  assign fast_osc_drive_n_o = st_r.fast_drv;
  assign system_phase_clock_o = st_r.system_phase_clock;
  assign reset_n_pin_o = 1'b0;
  assign reset_n_pin_oe_o = st_r.rst_oe;
  assign write_strobe_n_o = st_r.strobe_out;
  assign write_strobe_n_oe_o = st_r.strobe_oe;
  assign run_pin_o = st_r.run_pin;
  assign port_o = st_r.pout;
  assign port_oe_o = st_r.poe;
  assign port3_o = st_r.p3_pin;
  assign cpu_halt_o = st_r.halt;
  assign cpu_start_o = st_r.cpu_start;
  assign clk_restart_req_o = st_r.restart_req;
  assign low_power_o = st_r.low_power;
  assign ext_rdata_o = st_r.ext_rdata;
  assign ext_rdata_valid_o = st_r.ext_valid;
  assign dma_we_o = st_r.dma_we;
  assign dma_addr_o = st_r.dma_addr;
  assign dma_wdata_o = st_r.dma_wdata;

endmodule

// ===== common/pin_ctrl_pkg.sv
package pin_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_BUS_CONFIG = 8'h00;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h04;
  localparam logic [7:0] OFF_PORT_DATA = 8'h08;
  localparam logic [7:0] OFF_PORT_DIR = 8'h0C;
  localparam logic [7:0] OFF_PORT3 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // bus config fields
  localparam int BCR_EXT_BUS = 0;
  localparam int BCR_EMU = 3;
  localparam int BCR_EXT_MEM = 7;
  localparam logic [7:0] BCR_EMU_INIT = 8'h89;
  localparam logic [7:0] BCR_NORM_INIT = 8'h00;

  // timer control fields
  localparam int TCR_CLK_SEL = 1;
  localparam int TCR_FAST_GATE = 2;
  localparam logic [7:0] TCR_WR_MASK = 8'h06;
  localparam logic [7:0] TCR_RST = 8'h00;

  // status fields
  localparam int ST_RUN = 0;
  localparam int ST_CLK_STOP = 1;
  localparam int ST_DMA = 2;
  localparam int ST_LOW_POWER = 3;
  localparam int ST_SEQ_BUSY = 4;
  localparam int ST_BUS_GRANT = 5;

  // port reset values
  localparam logic [23:0] PORT_RST = 24'h000000;
  localparam logic [7:0] PORT3_DATA_RST = 8'hFF;
  localparam logic [7:0] PORT3_SEL_RST = 8'h00;

  // on-chip access fill values
  localparam logic [15:0] ADDR_ON_CHIP = 16'hFFFF;
  localparam logic [7:0] DATA_ON_CHIP = 8'hFF;

  // timing counts in phase-2 cycles / clk cycles
  localparam logic [3:0] RESET_SEQ_CYCLES = 4'h9;
  localparam logic [1:0] LOW_POWER_CYCLES = 2'h2;
  localparam logic [7:0] WDT_PULSE_CYCLES = 8'h10;

endpackage

// ===== rtl/sync_bank.sv
`timescale 1ns/100ps
module sync_bank #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule

// ===== test/pin_ctrl_props.sv
`timescale 1ns/100ps
module pin_ctrl_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic slow_osc_in_i,
  input wire logic slow_osc_drive_n_o,
  input wire logic system_phase_clock_o,
  input wire logic bus_grant_in_i,
  input wire logic reset_n_pin_i,
  input wire logic reset_n_pin_o,
  input wire logic reset_n_pin_oe_o,
  input wire logic write_strobe_n_o,
  input wire logic write_strobe_n_oe_o,
  input wire logic run_pin_o,
  input wire logic cpu_valid_i,
  input wire logic cpu_internal_i,
  input wire logic cpu_we_i,
  input wire logic wait_for_irq_instr_i,
  input wire logic stop_clock_instr_i,
  input wire logic irq_req_i,
  input wire logic wdt_timeout_i,
  input wire logic cpu_halt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] up_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end
  sequence s_ready;
    system_phase_clock_o && $past(system_phase_clock_o) && run_pin_o && !cpu_halt_o && !irq_req_i;
  endsequence
  sequence s_slow_still;
    ($stable(slow_osc_in_i) && reset_n_pin_i)[*6] ##0 up_r == 3'h7;
  endsequence
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_strobe_ext_wr: assert property (
    write_strobe_n_oe_o && !write_strobe_n_o |-> $past(cpu_valid_i) && $past(cpu_we_i) && !$past(cpu_internal_i))
    else $error("strobe low without external write");
  a_slow_drive_inv: assert property (s_slow_still |-> slow_osc_drive_n_o == !slow_osc_in_i)
    else $error("slow drive not inverted");
  a_wdt_pulls_pin: assert property ($rose(wdt_timeout_i) |-> ##[1:4] reset_n_pin_oe_o && !reset_n_pin_o)
    else $error("reset pin not pulled");
  a_run_on_release: assert property ($rose(reset_n_pin_i) && bus_grant_in_i |-> ##[2:8] run_pin_o)
    else $error("run low after release");
  a_wait_drops_run: assert property (wait_for_irq_instr_i ##0 s_ready |-> ##[1:4] !run_pin_o [*4])
    else $error("wait left run high");
  a_stop_holds_clk: assert property (
    stop_clock_instr_i ##0 s_ready |-> ##[1:4] (!run_pin_o && system_phase_clock_o) [*6])
    else $error("stop did not freeze clock");
  a_halt_on_run_low: assert property (
    $fell(run_pin_o) && system_phase_clock_o && $past(system_phase_clock_o) && reset_n_pin_i |-> ##[0:2] cpu_halt_o)
    else $error("run low without halt");
endmodule
bind pin_ctrl pin_ctrl_props pin_ctrl_props_inst (.*);

// ===== test/ext_side.sv
`timescale 1ns/100ps
module ext_side (
  // clock
  input wire logic clk_i,
  // device pins
  input wire logic [23:0] port_o,
  input wire logic [23:0] port_oe_o,
  input wire logic write_strobe_n_o,
  input wire logic write_strobe_n_oe_o,
  input wire logic reset_n_pin_o,
  input wire logic reset_n_pin_oe_o,
  // bench control
  input wire logic pin_lvl,
  input wire logic dma_on,
  input wire logic [23:0] dma_word,
  // resolved wires
  output logic [23:0] port_i,
  output logic write_strobe_n_i,
  output logic reset_n_pin_i
);
  logic [23:0] keep_r = 24'h5A5A5A;
  always_ff @(posedge clk_i) keep_r <= port_i;
  always_comb begin
    port_i = (port_oe_o & port_o) | (~port_oe_o & (dma_on ? dma_word : keep_r));
    write_strobe_n_i = write_strobe_n_oe_o ? write_strobe_n_o : !dma_on;
    reset_n_pin_i = reset_n_pin_oe_o ? reset_n_pin_o : pin_lvl;
  end
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pin_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq;
  logic slow_osc_in_i = 1'b0, fast_osc_in_i = 1'b0, bus_grant_in_i = 1'b1, pin_lvl = 1'b1, dma_on = 1'b0;
  logic slow_osc_drive_n_o, fast_osc_drive_n_o, system_phase_clock_o, run_pin_o;
  logic reset_n_pin_i, reset_n_pin_o, reset_n_pin_oe_o, write_strobe_n_i, write_strobe_n_o, write_strobe_n_oe_o;
  logic [23:0] port_i, port_o, port_oe_o;
  logic [23:0] dma_word = 24'h771234;
  logic [7:0] chip_select_n_i = 8'h5A, port3_o, ext_rdata_o, dma_wdata_o;
  logic cpu_valid_i = 1'b0, cpu_internal_i = 1'b0, cpu_we_i = 1'b0, cpu_sync_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h8000, dma_addr_o;
  logic [7:0] cpu_wdata_i = 8'hC3, cpu_idata_i = 8'h3C, dma_rdata_i = 8'h96;
  logic wait_for_irq_instr_i = 1'b0, stop_clock_instr_i = 1'b0, irq_req_i = 1'b0, wdt_timeout_i = 1'b0;
  logic cpu_halt_o, cpu_start_o, clk_restart_req_o, low_power_o, ext_rdata_valid_o, dma_we_o;
  logic [3:0] div = 4'h0;
  int err_count = 0;
  int n_checks = 0;
  int k;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    div <= div + 4'h1;
    slow_osc_in_i <= div[3];
    fast_osc_in_i <= div[1];
  end
  pin_ctrl #(.WDT_PULSE(8'h08)) pin_ctrl_inst (.*);
  ext_side ext_side_inst (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    chk({31'h0, wb_ack_o}, 32'h1);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hF, 32'h0);
    chk(rq, exp);
  endtask
  task ph(input logic v);
    k = 0;
    while (system_phase_clock_o !== v && k < 200) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task automatic hold_for(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task t_regs;
    rd(OFF_BUS_CONFIG, {24'h0, BCR_NORM_INIT});
    rd(OFF_TIMER_CTRL, {24'h0, TCR_RST});
    rd(OFF_PORT3, {16'h0, PORT3_SEL_RST, PORT3_DATA_RST});
    rd(OFF_PORT_DIR, {8'h0, PORT_RST});
    wb(1'b1, 8'h18, 4'hF, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    $display("registers done");
  endtask
  task t_ports;
    wb(1'b1, OFF_PORT_DIR, 4'hF, 32'h0000FF);
    wb(1'b1, OFF_PORT_DATA, 4'h1, 32'hFFFFA5);
    cyc_n(4);
    chk({8'h0, port_oe_o}, 32'hFF);
    chk({24'h0, port_o[7:0]}, 32'hA5);
    rd(OFF_PORT_DATA, 32'h5A5AA5);
    wb(1'b1, OFF_PORT3, 4'h3, 32'h0F3C);
    cyc_n(4);
    chk({24'h0, port3_o}, 32'h3A);
    $display("ports done");
  endtask
  task t_clock;
    int r;
    logic p;
    chk({31'h0, fast_osc_drive_n_o}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      ph(1'b1);
      ph(1'b0);
      r = 0;
      p = 1'b0;
      // count phase rises in a fixed 64-cycle window
      repeat (64) begin
        @(posedge clk_i);
        if (system_phase_clock_o === 1'b1 && p === 1'b0) r++;
        p = system_phase_clock_o;
      end
      chk(r, m ? 16 : 4);
      wb(1'b1, OFF_TIMER_CTRL, 4'hF, m ? 32'h0 : 32'hFF);
      if (!m) rd(OFF_TIMER_CTRL, 32'h06);
    end
    $display("clock done");
  endtask
  task sleep(input logic s);
    ph(1'b1);
    ph(1'b0);
    ph(1'b1);
    cyc_n(2);
    if (s) stop_clock_instr_i <= 1'b1;
    else wait_for_irq_instr_i <= 1'b1;
    @(posedge clk_i);
    stop_clock_instr_i <= 1'b0;
    wait_for_irq_instr_i <= 1'b0;
    cyc_n(30);
    chk({30'h0, run_pin_o, cpu_halt_o}, 32'h1);
    rd(OFF_STATUS, s ? 32'h22 : 32'h20);
    irq_req_i <= 1'b1;
    hold_for(clk_restart_req_o);
    chk({31'h0, clk_restart_req_o}, 32'h1);
    irq_req_i <= 1'b0;
    cyc_n(4);
    chk({30'h0, run_pin_o, cpu_halt_o}, 32'h2);
    $display("sleep done");
  endtask
  task t_wdt;
    int n;
    // grant dropped in phase high: halt only
    ph(1'b0);
    ph(1'b1);
    bus_grant_in_i <= 1'b0;
    cyc_n(4);
    chk({30'h0, cpu_halt_o, write_strobe_n_oe_o}, 32'h3);
    bus_grant_in_i <= 1'b1;
    wb(1'b1, OFF_TIMER_CTRL, 4'hF, 32'h04);
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    hold_for(reset_n_pin_oe_o);
    n = 0;
    while (reset_n_pin_oe_o === 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, 8);
    cyc_n(12);
    rd(OFF_TIMER_CTRL, 32'h0);
    rd(OFF_PORT_DIR, 32'h0);
    rd(OFF_PORT3, 32'hFF);
    chk({31'h0, run_pin_o}, 32'h1);
    $display("watchdog done");
  endtask
  task t_emu;
    int r;
    logic p;
    bus_grant_in_i <= 1'b0;
    pin_lvl <= 1'b0;
    cyc_n(48);
    chk({7'h0, low_power_o, port_oe_o}, 32'h1000000);
    pin_lvl <= 1'b1;
    // phase is frozen high in low power, so every rise counted is after release
    r = 0;
    p = 1'b1;
    k = 0;
    while (cpu_start_o !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
      if (system_phase_clock_o === 1'b1 && p === 1'b0) r++;
      p = system_phase_clock_o;
    end
    chk(r, 9);
    rd(OFF_BUS_CONFIG, {24'h0, BCR_EMU_INIT});
    bus_grant_in_i <= 1'b1;
    ph(1'b1);
    ph(1'b0);
    cyc_n(3);
    chk({31'h0, run_pin_o}, 32'h0);
    cpu_sync_i <= 1'b1;
    cyc_n(2);
    chk({31'h0, run_pin_o}, 32'h1);
    cpu_sync_i <= 1'b0;
    cpu_internal_i <= 1'b1;
    cpu_valid_i <= 1'b1;
    cpu_we_i <= 1'b1;
    ph(1'b1);
    cyc_n(3);
    chk({30'h0, write_strobe_n_o, write_strobe_n_oe_o, run_pin_o}, 32'h7);
    chk({24'h0, port_oe_o[23:16] & port_o[23:16]}, 32'hC3);
    cpu_internal_i <= 1'b0;
    cyc_n(2);
    chk({31'h0, write_strobe_n_o}, 32'h0);
    // external read: far side supplies the data lanes
    ph(1'b0);
    cpu_we_i <= 1'b0;
    dma_on <= 1'b1;
    hold_for(ext_rdata_valid_o);
    chk({24'h0, ext_rdata_o}, 32'h77);
    cpu_valid_i <= 1'b0;
    bus_grant_in_i <= 1'b0;
    hold_for(dma_we_o);
    chk({8'h0, dma_addr_o, dma_wdata_o}, 32'h123477);
    chk({15'h0, write_strobe_n_oe_o, port_oe_o[15:0]}, 32'h0);
    dma_on <= 1'b0;
    bus_grant_in_i <= 1'b1;
    $display("emulation done");
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(5 * 20000);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc_n(6);
    t_regs;
    t_ports;
    t_clock;
    sleep(1'b0);
    sleep(1'b1);
    t_wdt;
    t_emu;
    give_verdict;
  end
endmodule
